// ---- src/tcc_core.sv ----
// Eight-bit timer/counter with one output compare channel
//
// Behaviour
// [R1] Count value 0x00 is the bottom of the range.
// [R2] Count value 0xFF is the maximum of the range.
// [R3] Top is 0xFF or the compare value, chosen by mode.
// [R4] Count value and compare value are eight-bit registers.
// [R5] Every request shows as a flag and has its own mask bit.
// [R6] Tick comes from prescaler or external pin; select zero stops the timer.
// [R7] Each tick clears, increments or decrements the count per mode.
// [R8] Software reads and writes the count whether ticking or not.
// [R9] A software count write beats any clear or count that cycle.
// [R10] Two waveform mode bits in the control register set the count sequence.
// [R11] Overflow flag set per mode and can raise an interrupt.
// [R12] Count equal to compare sets the compare flag on the next tick.
// [R13] Compare interrupt needs its enable bit and the global enable.
// [R14] Compare flag clears on interrupt execution or writing one.
// [R15] Output logic uses match, mode, output mode, max and bottom.
// [R16] Compare value double buffered in PWM modes, not otherwise.
// [R17] Buffered value loads into the active register at top or bottom.
// [R18] Software compare access hits buffer when buffered, else active register.
// [R19] Force strobe acts like a match on the output only, non-PWM modes.
// [R20] A count write blocks compare matches at the next tick, stopped or not.
// [R21] Output state is kept across waveform mode changes.
// [R22] Output mode bits take effect at once, unbuffered.
// [R23] Output mode zero leaves the output state alone at a match.
// [R24] Reset clears the output state.
// [R25] Nonzero output mode routes output state to the pin; direction bit stays.
// [R26] Mode 0 normal, 2 clear-on-match, 3 fast PWM.
// [R27] Mode 1 is phase-correct PWM between bottom and maximum.
// [R28] Reset clears count, compare, buffer, control, flags and masks.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tcc_core
  import tcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_count_input,
  input  wire logic       cpu_status_gie,
  input  wire logic       irq_ack_overflow,
  input  wire logic       irq_ack_compare,
  output logic            irq_overflow,
  output logic            irq_compare,
  input  wire logic       port_data_bit,
  input  wire logic       port_dir_bit,
  output logic            compare_output_pin_o,
  output logic            compare_output_pin_oe
);

  typedef struct packed {
    logic [7:0] count_value;  // R4
    logic [7:0] compare_value;  // R4
    logic [7:0] compare_buf;
    logic [2:0] clock_select_field;
    logic [1:0] waveform_mode_field;
    logic [1:0] compare_output_mode_field;
    logic       count_down;
    logic       overflow_flag;
    logic       compare_flag;
    logic       overflow_irq_enable;
    logic       compare_irq_enable;
    logic       match_block;
    logic       compare_output;
    logic       pin_o;
    logic       pin_oe;
    logic [7:0] rdata;
  } tcc_state_t;

  tcc_state_t s_r;
  tcc_state_t s_nxt;
  logic       timer_tick;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_pwm(input logic [1:0] wgm);
    is_pwm = (wgm == TCC_WGM_PHASE) || (wgm == TCC_WGM_FAST);
  endfunction

  // Non-PWM output action, shared by a real match and the force strobe
  function automatic logic com_action(input logic [1:0] com, input logic cur);
    case (com)
      TCC_COM_TOGGLE: com_action = ~cur;
      TCC_COM_CLEAR:  com_action = 1'b0;
      TCC_COM_SET:    com_action = 1'b1;
      default:        com_action = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  tcc_tick_gen u_tick (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .clock_select_field (s_r.clock_select_field),
    .ext_count_input    (ext_count_input),
    .timer_tick         (timer_tick)
  );

  logic at_bottom;
  logic at_max;
  logic match;
  logic eff_match;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flag;
  logic wr_mask;

  assign at_bottom = s_r.count_value == TCC_BOTTOM;  // R1
  assign at_max    = s_r.count_value == TCC_MAX;     // R2
  assign match     = s_r.count_value == s_r.compare_value;  // R12
  assign eff_match = timer_tick && match && !s_r.match_block;  // R20
  assign wr_ctrl   = reg_wr && (reg_addr == TCC_OFS_CTRL);
  assign wr_cnt    = reg_wr && (reg_addr == TCC_OFS_CNT);
  assign wr_cmp    = reg_wr && (reg_addr == TCC_OFS_CMP);
  assign wr_flag   = reg_wr && (reg_addr == TCC_OFS_FLAG);
  assign wr_mask   = reg_wr && (reg_addr == TCC_OFS_MASK);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ovf_set;
    logic cmp_set;
    logic [1:0] wgm;
    logic [1:0] com;
    ovf_set = 1'b0;
    cmp_set = 1'b0;
    s_nxt   = s_r;
    wgm     = s_r.waveform_mode_field;
    com     = s_r.compare_output_mode_field;
    // Counting sequence
    if (timer_tick) begin
      case (wgm)  // R10 R26 R27
        TCC_WGM_CTC: begin
          // Top is the compare value here; 0xFF wraps only on a missed match
          if (match) begin  // R3
            s_nxt.count_value = TCC_BOTTOM;  // R7
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
          ovf_set = at_max;  // R11
        end
        TCC_WGM_PHASE: begin
          if (s_r.count_down) begin
            if (at_bottom) begin
              s_nxt.count_down  = 1'b0;
              s_nxt.count_value = s_r.count_value + 8'h01;
              ovf_set           = 1'b1;  // R11
            end else begin
              s_nxt.count_value = s_r.count_value - 8'h01;  // R7
            end
          end else if (at_max) begin  // R3
            s_nxt.count_down  = 1'b1;
            s_nxt.count_value = s_r.count_value - 8'h01;
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
        end
        default: begin
          s_nxt.count_value = s_r.count_value + 8'h01;  // R7
          ovf_set           = at_max;  // R11
        end
      endcase
      s_nxt.match_block = 1'b0;
      cmp_set           = eff_match;  // R12
    end
    // Buffered compare reaches the active register on the tick at max only, in both PWM modes
    if (is_pwm(wgm) && timer_tick && at_max) begin  // R16 R17
      s_nxt.compare_value = s_r.compare_buf;
    end
    // Output state; output mode read live each cycle
    if (eff_match && com != TCC_COM_NONE) begin  // R15 R22 R23
      case (wgm)
        TCC_WGM_FAST: begin
          // Output mode one is reserved in PWM: leave the state alone
          if (com[1]) begin
            s_nxt.compare_output = (com == TCC_COM_SET);
          end
        end
        TCC_WGM_PHASE: begin
          if (com == TCC_COM_SET || com == TCC_COM_CLEAR) begin
            s_nxt.compare_output = (com == TCC_COM_SET) ^ s_r.count_down;
          end
        end
        default: s_nxt.compare_output = com_action(com, s_r.compare_output);
      endcase
    end
    // Bottom restores the fast PWM level; it wins over a match at max
    if (wgm == TCC_WGM_FAST && timer_tick && at_max && com[1]) begin  // R15
      s_nxt.compare_output = (com == TCC_COM_CLEAR);
    end
    // Software writes come last so they win over the tick
    if (wr_ctrl) begin
      s_nxt.clock_select_field        = reg_wdata[TCC_CS_LSB +: 3];  // R6
      s_nxt.waveform_mode_field       = reg_wdata[TCC_WGM_LSB +: 2];  // R21
      s_nxt.compare_output_mode_field = reg_wdata[TCC_COM_LSB +: 2];  // R22
      // Force obeys the mode written beside it, not the old one
      if (reg_wdata[TCC_FOC_BIT] && !is_pwm(reg_wdata[TCC_WGM_LSB +: 2])) begin  // R19
        s_nxt.compare_output = com_action(reg_wdata[TCC_COM_LSB +: 2], s_r.compare_output);
      end
    end
    if (wr_cnt) begin
      s_nxt.count_value = reg_wdata;  // R8 R9
      s_nxt.match_block = 1'b1;  // R20
    end
    if (wr_cmp) begin
      s_nxt.compare_buf = reg_wdata;  // R18
      if (!is_pwm(wgm)) begin
        s_nxt.compare_value = reg_wdata;  // R16 R18
      end
    end
    if (wr_mask) begin
      s_nxt.overflow_irq_enable = reg_wdata[TCC_OVF_BIT];  // R5
      s_nxt.compare_irq_enable  = reg_wdata[TCC_CMP_BIT];  // R5
    end
    // Flags: a set in the clearing cycle survives
    s_nxt.overflow_flag = (s_r.overflow_flag & ~((wr_flag & reg_wdata[TCC_OVF_BIT]) | irq_ack_overflow))
                          | ovf_set;  // R5 R11
    s_nxt.compare_flag  = (s_r.compare_flag & ~((wr_flag & reg_wdata[TCC_CMP_BIT]) | irq_ack_compare))
                          | cmp_set;  // R14
    // Read data appears the cycle after the strobe only
    s_nxt.rdata = TCC_RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        TCC_OFS_CTRL: s_nxt.rdata = {1'b0, s_r.compare_output_mode_field,
                                     s_r.waveform_mode_field, s_r.clock_select_field};
        TCC_OFS_CNT:  s_nxt.rdata = s_r.count_value;  // R8
        TCC_OFS_CMP:  s_nxt.rdata = is_pwm(wgm) ? s_r.compare_buf : s_r.compare_value;  // R18
        TCC_OFS_FLAG: s_nxt.rdata = {6'h00, s_r.compare_flag, s_r.overflow_flag};
        TCC_OFS_MASK: s_nxt.rdata = {6'h00, s_r.compare_irq_enable, s_r.overflow_irq_enable};
        default:      s_nxt.rdata = TCC_RST_BYTE;
      endcase
    end
    // Pin override; direction stays with the port
    s_nxt.pin_o  = (s_nxt.compare_output_mode_field != TCC_COM_NONE) ? s_nxt.compare_output
                   : port_data_bit;  // R25
    s_nxt.pin_oe = port_dir_bit;  // R25
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;  // R24 R28
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata             = s_r.rdata;
  assign irq_overflow          = s_r.overflow_flag & s_r.overflow_irq_enable & cpu_status_gie;  // R5 R11
  assign irq_compare           = s_r.compare_flag & s_r.compare_irq_enable & cpu_status_gie;  // R13
  assign compare_output_pin_o  = s_r.pin_o;
  assign compare_output_pin_oe = s_r.pin_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_count_write;
    wr_cnt;
  endsequence

  sequence s_blocked_tick;
    s_r.match_block && timer_tick && !wr_flag && !irq_ack_compare;
  endsequence

  a_normal_wrap: assert property (  // R1 R2 R11
    timer_tick && at_max && !wr_cnt && s_r.waveform_mode_field == TCC_WGM_NORMAL
    |=> s_r.count_value == TCC_BOTTOM && s_r.overflow_flag)
    else $error("normal mode did not wrap with overflow");

  a_stop_holds: assert property (  // R6
    s_r.clock_select_field == TCC_CS_STOP && !wr_ctrl && !wr_cnt ##1 !wr_cnt
    |=> $stable(s_r.count_value))
    else $error("stopped timer changed count");

  a_cpu_write_wins: assert property (  // R9
    s_count_write |=> s_r.count_value == $past(reg_wdata))
    else $error("count write lost to tick");

  a_match_blocked: assert property (  // R20
    s_blocked_tick |=> s_r.compare_flag == $past(s_r.compare_flag))
    else $error("match not blocked after count write");

  a_match_sets_flag: assert property (  // R12
    timer_tick && match && !s_r.match_block |=> s_r.compare_flag)
    else $error("compare flag not set on match");

  a_irq_gating: assert property (  // R13
    irq_compare |-> cpu_status_gie && s_r.compare_irq_enable && s_r.compare_flag)
    else $error("compare irq without enables");

  a_flag_clear: assert property (  // R14
    irq_ack_compare && !(timer_tick && match) |=> !s_r.compare_flag)
    else $error("compare flag not cleared on ack");

  a_buffer_hold: assert property (  // R16 R17
    is_pwm(s_r.waveform_mode_field) && !(timer_tick && at_max) && !wr_ctrl
    |=> s_r.compare_value == $past(s_r.compare_value))
    else $error("buffered compare moved off top");

  a_force_output: assert property (  // R19
    wr_ctrl && reg_wdata[TCC_FOC_BIT] && !is_pwm(reg_wdata[TCC_WGM_LSB +: 2])
    && reg_wdata[TCC_COM_LSB +: 2] == TCC_COM_SET
    |=> s_r.compare_output ##1 s_r.pin_o)
    else $error("force strobe did not set output");

  a_com_zero_idle: assert property (  // R23
    s_r.compare_output_mode_field == TCC_COM_NONE && !wr_ctrl
    |=> $stable(s_r.compare_output))
    else $error("output changed with mode zero");

  a_ctc_clear: assert property (  // R3 R7
    timer_tick && match && !wr_cnt && s_r.waveform_mode_field == TCC_WGM_CTC
    |=> s_r.count_value == TCC_BOTTOM)
    else $error("clear-on-match mode did not clear");

  a_phase_turn: assert property (  // R27
    timer_tick && at_max && !s_r.count_down && !wr_cnt && s_r.waveform_mode_field == TCC_WGM_PHASE
    |=> s_r.count_down && s_r.count_value == TCC_MAX - 8'h01)
    else $error("dual-slope count did not turn at max");

  a_pin_route: assert property (  // R25
    s_r.compare_output_mode_field != TCC_COM_NONE && !wr_ctrl
    |=> s_r.pin_o == s_r.compare_output)
    else $error("pin not driven from output state");

endmodule

// ---- src/tcc_pkg.sv ----
// Shared constants for the eight-bit timer/counter core
package tcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] TCC_OFS_CTRL = 3'h0;
  localparam logic [2:0] TCC_OFS_CNT  = 3'h1;
  localparam logic [2:0] TCC_OFS_CMP  = 3'h2;
  localparam logic [2:0] TCC_OFS_FLAG = 3'h3;
  localparam logic [2:0] TCC_OFS_MASK = 3'h4;

  // ----------------------------------------------------------------
  // Field positions in timer_control_reg and the flag/mask registers
  // ----------------------------------------------------------------
  localparam int TCC_CS_LSB  = 0;
  localparam int TCC_WGM_LSB = 3;
  localparam int TCC_COM_LSB = 5;
  localparam int TCC_FOC_BIT = 7;
  localparam int TCC_OVF_BIT = 0;
  localparam int TCC_CMP_BIT = 1;

  // ----------------------------------------------------------------
  // Count values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_BOTTOM    = 8'h00;
  localparam logic [7:0] TCC_MAX       = 8'hFF;
  localparam logic [7:0] TCC_RST_BYTE  = 8'h00;
  localparam logic [9:0] TCC_RST_PRE   = 10'h000;

  // ----------------------------------------------------------------
  // Prescaler tap masks (divide by 8, 64, 256, 1024)
  // ----------------------------------------------------------------
  localparam logic [9:0] TCC_DIV8_MASK    = 10'h007;
  localparam logic [9:0] TCC_DIV64_MASK   = 10'h03F;
  localparam logic [9:0] TCC_DIV256_MASK  = 10'h0FF;
  localparam logic [9:0] TCC_DIV1024_MASK = 10'h3FF;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TCC_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TCC_WGM_PHASE  = 2'h1;
  localparam logic [1:0] TCC_WGM_CTC    = 2'h2;
  localparam logic [1:0] TCC_WGM_FAST   = 2'h3;

  localparam logic [1:0] TCC_COM_NONE   = 2'h0;
  localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TCC_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TCC_COM_SET    = 2'h3;

  localparam logic [2:0] TCC_CS_STOP     = 3'h0;
  localparam logic [2:0] TCC_CS_DIV1     = 3'h1;
  localparam logic [2:0] TCC_CS_DIV8     = 3'h2;
  localparam logic [2:0] TCC_CS_DIV64    = 3'h3;
  localparam logic [2:0] TCC_CS_DIV256   = 3'h4;
  localparam logic [2:0] TCC_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;

endpackage

// ---- src/tcc_tick_gen.sv ----
// Clock select: prescaler and synchronised external count input
`timescale 1ns/1ps
module tcc_tick_gen
  import tcc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       ext_count_input,
  output logic            timer_tick
);

  typedef struct packed {
    logic [9:0] pre;
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic       tick;
  } tcc_tick_state_t;

  tcc_tick_state_t s_r;
  tcc_tick_state_t s_nxt;

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.pre   = s_r.pre + 10'h001;
    s_nxt.sync1 = ext_count_input;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    case (clock_select_field)
      TCC_CS_STOP:     s_nxt.tick = 1'b0;
      TCC_CS_DIV1:     s_nxt.tick = 1'b1;
      TCC_CS_DIV8:     s_nxt.tick = (s_r.pre & TCC_DIV8_MASK) == TCC_RST_PRE;
      TCC_CS_DIV64:    s_nxt.tick = (s_r.pre & TCC_DIV64_MASK) == TCC_RST_PRE;
      TCC_CS_DIV256:   s_nxt.tick = (s_r.pre & TCC_DIV256_MASK) == TCC_RST_PRE;
      TCC_CS_DIV1024:  s_nxt.tick = (s_r.pre & TCC_DIV1024_MASK) == TCC_RST_PRE;
      // Edge seen on the second stage only, never on the first
      TCC_CS_EXT_FALL: s_nxt.tick = s_r.prev & ~s_r.sync2;
      TCC_CS_EXT_RISE: s_nxt.tick = ~s_r.prev & s_r.sync2;
      default:         s_nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timer_tick = s_r.tick;

endmodule

// ---- tb/tcc_far_side.sv ----
// Far side model: external event source and compare pin load
`timescale 1ns/1ps
module tcc_far_side (
  input  wire logic core_clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      ext_count_input,
  output logic      pin_level
);
  logic last_r;

  // Undriven pin floats: show the inverse of the last driven level
  always @(posedge core_clk) begin
    if (pin_oe)
      last_r <= pin_o;
  end
  assign pin_level = pin_oe ? pin_o : ~last_r;

  initial ext_count_input = 1'h0;

  // Six cycles per level, well past the two-flop synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (6) @(posedge core_clk);
      ext_count_input <= 1'h1;
      repeat (6) @(posedge core_clk);
      ext_count_input <= 1'h0;
    end
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the timer/counter core
`timescale 1ns/1ps
module testbench
  import tcc_pkg::*;
;
  logic       core_clk, rstn, reg_wr, reg_rd, gie, ack_ovf, ack_cmp;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic       ext_in, irq_ovf, irq_cmp, pdata, pdir, pin_o, pin_oe, pin_lvl;
  logic [7:0] exp_q[$];
  logic       rd_pend;
  logic [1:0] fcm[3] = '{TCC_COM_TOGGLE, TCC_COM_CLEAR, TCC_COM_SET};
  logic       fpv[3] = '{1'h0, 1'h0, 1'h1};
  int         num_errors, checks, cycles, seed;

  initial core_clk = 1'h0;
  always #2.5 core_clk = ~core_clk;

  tcc_core tcc_core_inst (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(ext_in),
    .cpu_status_gie(gie), .irq_ack_overflow(ack_ovf), .irq_ack_compare(ack_cmp),
    .irq_overflow(irq_ovf), .irq_compare(irq_cmp), .port_data_bit(pdata),
    .port_dir_bit(pdir), .compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe)
  );

  tcc_far_side tcc_far_side_inst (
    .core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_count_input(ext_in), .pin_level(pin_lvl)
  );

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) rd_pend <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_pend === 1'h1)
      check("read data", reg_rdata, exp_q.pop_front());
    else
      check("idle read data", reg_rdata, 8'h00);
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Bus and pin helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wg,
                                     input logic [1:0] cm, input logic f);
    return {f, cm, wg, cs};
  endfunction

  task automatic pin_is(input logic e);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("pin level", {7'h00, pin_lvl}, {7'h00, e});
    @(posedge core_clk);
  endtask

  task automatic irq_is(input logic o, input logic c);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("overflow irq", {7'h00, irq_ovf}, {7'h00, o});
    check("compare irq", {7'h00, irq_cmp}, {7'h00, c});
    @(posedge core_clk);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'h0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'h1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h9CFB;
    {rstn, reg_wr, reg_rd, gie, ack_ovf, ack_cmp, pdata, pdir} = 8'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    do_reset();
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    pdir <= 1'h1;
    v = 8'($random(seed));
    pdata <= v[0];
    pin_is(v[0]);
    repeat (4) begin
      v = 8'($random(seed));
      wr(TCC_OFS_CNT, v);
      rd(TCC_OFS_CNT, v);
    end
    tcc_far_side_inst.pulse(5);
    rd(TCC_OFS_CNT, v);
    // Wrap through max and bottom; compare value zero matches too
    wr(TCC_OFS_CNT, 8'hFE);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_RISE, TCC_WGM_NORMAL, TCC_COM_NONE, 1'h0));
    tcc_far_side_inst.pulse(3);
    rd(TCC_OFS_CNT, 8'h01);
    rd(TCC_OFS_FLAG, 8'h03);
    wr(TCC_OFS_FLAG, 8'h00);
    rd(TCC_OFS_FLAG, 8'h03);
    wr(TCC_OFS_MASK, 8'h01);
    gie <= 1'h1;
    irq_is(1'h1, 1'h0);
    gie <= 1'h0;
    irq_is(1'h0, 1'h0);
    gie <= 1'h1;
    @(posedge core_clk);
    ack_ovf <= 1'h1;
    @(posedge core_clk);
    ack_ovf <= 1'h0;
    rd(TCC_OFS_FLAG, 8'h02);
    wr(TCC_OFS_FLAG, 8'h02);
    rd(TCC_OFS_FLAG, 8'h00);
    wr(TCC_OFS_CMP, 8'h05);
    rd(TCC_OFS_CMP, 8'h05);
    wr(TCC_OFS_CNT, 8'h03);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_RISE, TCC_WGM_NORMAL, TCC_COM_TOGGLE, 1'h0));
    tcc_far_side_inst.pulse(2);
    rd(TCC_OFS_FLAG, 8'h00);
    tcc_far_side_inst.pulse(1);
    rd(TCC_OFS_FLAG, 8'h02);
    pin_is(1'h1);
    wr(TCC_OFS_MASK, 8'h02);
    irq_is(1'h0, 1'h1);
    // Random global enable and pin direction
    repeat (4) begin
      v = 8'($random(seed));
      gie  <= v[0];
      pdir <= v[1];
      irq_is(1'h0, v[0]);
      @(negedge core_clk);
      check("pin enable", {7'h00, pin_oe}, {7'h00, v[1]});
      @(posedge core_clk);
    end
    pdir <= 1'h1;
    @(posedge core_clk);
    ack_cmp <= v[2];
    @(posedge core_clk);
    ack_cmp <= 1'h0;
    rd(TCC_OFS_FLAG, {6'h00, ~v[2], 1'h0});
    @(posedge core_clk);
    ack_cmp <= 1'h1;
    @(posedge core_clk);
    ack_cmp <= 1'h0;
    rd(TCC_OFS_FLAG, 8'h00);
    // Count write equal to compare must not match at next tick
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_COM_NONE, 1'h0));
    wr(TCC_OFS_CMP, 8'h07);
    wr(TCC_OFS_CNT, 8'h07);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_FALL, TCC_WGM_NORMAL, TCC_COM_NONE, 1'h0));
    tcc_far_side_inst.pulse(1);
    rd(TCC_OFS_FLAG, 8'h00);
    wr(TCC_OFS_CNT, 8'h06);
    tcc_far_side_inst.pulse(2);
    rd(TCC_OFS_FLAG, 8'h02);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_COM_CLEAR, 1'h0));
    pin_is(1'h1);
    wr(TCC_OFS_FLAG, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, fcm[i], 1'h1));
      pin_is(fpv[i]);
    end
    rd(TCC_OFS_FLAG, 8'h00);
    rd(TCC_OFS_CNT, 8'h08);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_FAST, TCC_COM_CLEAR, 1'h1));
    pin_is(1'h1);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_PHASE, TCC_COM_SET, 1'h1));
    pin_is(1'h1);
    // Buffered compare loads only when the count passes max
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_FAST, TCC_COM_NONE, 1'h0));
    wr(TCC_OFS_CMP, 8'h40);
    rd(TCC_OFS_CMP, 8'h40);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_COM_NONE, 1'h0));
    rd(TCC_OFS_CMP, 8'h07);
    wr(TCC_OFS_CNT, 8'hFE);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_RISE, TCC_WGM_FAST, TCC_COM_NONE, 1'h0));
    tcc_far_side_inst.pulse(2);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_COM_NONE, 1'h0));
    rd(TCC_OFS_CMP, 8'h40);
    wr(TCC_OFS_CMP, 8'h02);
    wr(TCC_OFS_CNT, 8'h00);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_FALL, TCC_WGM_CTC, TCC_COM_NONE, 1'h0));
    tcc_far_side_inst.pulse(3);
    rd(TCC_OFS_CNT, 8'h00);
    // Second reset in mid-run, then dual-slope counting
    do_reset();
    for (int a = 0; a < 5; a++) rd(3'(a), 8'h00);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_COM_SET, 1'h0));
    pin_is(1'h0);
    wr(TCC_OFS_CNT, 8'hFD);
    wr(TCC_OFS_CTRL, ctl(TCC_CS_EXT_RISE, TCC_WGM_PHASE, TCC_COM_NONE, 1'h0));
    tcc_far_side_inst.pulse(4);
    rd(TCC_OFS_CNT, 8'hFD);
    repeat (2) @(posedge core_clk);
    conclude();
  end
endmodule
